// ===== design/mm_addr_decode.sv
`timescale 1ns/1ns
`default_nettype none
module mm_addr_decode #(
    parameter int unsigned RAM_BYTES = 1024
) (
    input wire logic [15:0] addr,
    output mm_pkg::mm_region_t region,
    output logic [9:0] ram_off,
    output logic [5:0] vec_off
);
    localparam logic [15:0] RAM_END = 16'(mm_pkg::RAM_FIRST + RAM_BYTES - 1);
    logic [15:0] ram_diff;
    logic [15:0] vec_diff;

    // offsets into ram and vector table
    assign ram_diff = addr - mm_pkg::RAM_FIRST;
    assign vec_diff = addr - mm_pkg::VEC_FIRST;
    assign ram_off = ram_diff[9:0];
    assign vec_off = vec_diff[5:0];

    // region select, page zero ram included in ram
    always_comb begin
        if (addr >= mm_pkg::RAM_FIRST && addr <= RAM_END) begin
            region = mm_pkg::RGN_RAM;
        end else if (addr >= mm_pkg::UROM_FIRST
                     && addr <= mm_pkg::UROM_LAST) begin
            region = mm_pkg::RGN_UROM;
        end else if (addr >= mm_pkg::MROM_FIRST
                     && addr <= mm_pkg::MROM_LAST) begin
            region = mm_pkg::RGN_MROM;
        end else if (addr >= mm_pkg::VEC_FIRST) begin
            region = mm_pkg::RGN_VEC;
        end else if (addr == mm_pkg::IDX_DIVH_NV
                     || addr == mm_pkg::IDX_DIVL_NV
                     || (addr >= mm_pkg::IDX_DIVH
                         && addr <= mm_pkg::IDX_PROT_ACT
                         && addr != 16'hFE1E)) begin
            region = mm_pkg::RGN_REG;
        end else begin
            region = mm_pkg::RGN_NONE;
        end
    end
endmodule : mm_addr_decode
`default_nettype wire

// ===== design/mm_map_top.sv
// Notes on behaviour
// - reset loads divider high from its nv copy, bits 6..3 forced zero
// - reset loads divider low from its nv copy
// - nv protect register survives reset; blank reads all ones, factory F0
// - control register resets to zero; bit 6 reads zero
// - watchdog location reads reset vector low; a write clears watchdog
// - two-byte vectors from periodic timer pair up to reset pair
// - ram decoded at 0050 through 044F, 1024 bytes
// - page zero holds 176 ram bytes, directly addressable
// - stack pointer is 16 bits, resets to 00FF, loadable anywhere
// - interrupt entry stacks five bytes
// - index high register is not stacked on interrupt
// - subroutine call stacks a two-byte return address
// - stack pointer decrements on push, increments on pull
// - user rom decoded at 8000 through FDFF
// - monitor rom decoded at FE20 through FEFF, vectors at FFDA through FFFF
// - user rom is unreadable from outside while security holds
// - reset on aresetn copies nv configuration into volatile registers; por_n alone does not
`timescale 1ns/1ns
`default_nettype none
module mm_map_top #(
    parameter int unsigned RAM_BYTES = 1024,
    parameter logic [15:0] RESET_VECTOR = 16'h8000,
    parameter logic [35:0][7:0] VECTORS = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic rom_secure,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mm_pkg::mm_sop_t cpu_stack_op,
    input wire logic [15:0] cpu_sp_load_val,
    output logic [15:0] stack_ptr,
    output logic stack_in_ram,
    output logic [10:0] timebase_divider,
    output logic divider_security_bit,
    output logic [7:0] array_protect_active,
    output logic [7:0] array_program_control,
    output logic watchdog_clear
);
    // --------
    // parameter checks
    // --------
    if (RAM_BYTES < 176 || RAM_BYTES > 1024) begin : g_bad_ram
        $error("RAM_BYTES must lie between 176 and 1024");
    end

    // --------
    // state
    // --------
    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] ram;
        logic [7:0] nv_divh;
        logic [7:0] nv_divl;
        logic [7:0] nv_prot;
        logic [7:0] divh;
        logic [7:0] divl;
        logic [7:0] prot_act;
        logic [7:0] ctrl;
        logic latched;
        logic [15:0] latch_idx;
        logic [7:0] latch_data;
        logic aw_have;
        logic [15:0] aw_idx;
        logic w_have;
        logic [7:0] wbyte;
        logic wlane0;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rbyte;
        logic wdog_clr;
    } mm_state_t;
    mm_state_t st_q;
    mm_state_t st_d;

    mm_pkg::mm_region_t wr_region;
    mm_pkg::mm_region_t rd_region;
    logic [9:0] wr_ram_off;
    logic [9:0] rd_ram_off;
    logic [5:0] rd_vec_off;
    logic [15:0] rd_idx;
    logic [15:0] wr_idx;
    logic [7:0] prog_val;
    logic erase_sel;

    // --------
    // address decoders and stack pointer
    // --------
    // write index: taken at this edge, else the one held
    assign wr_idx = (st_q.awready && s_axi_awvalid) ? s_axi_awaddr[17:2]
                    : st_q.aw_idx;

    mm_addr_decode #(.RAM_BYTES(RAM_BYTES)) u_wr_dec (
        .addr(wr_idx),
        .region(wr_region),
        .ram_off(wr_ram_off),
        .vec_off()
    );

    assign rd_idx = s_axi_araddr[17:2];

    mm_addr_decode #(.RAM_BYTES(RAM_BYTES)) u_rd_dec (
        .addr(rd_idx),
        .region(rd_region),
        .ram_off(rd_ram_off),
        .vec_off(rd_vec_off)
    );

    mm_stack_if stk ();

    assign stk.op = cpu_stack_op;
    assign stk.load_val = cpu_sp_load_val;

    mm_stack_ptr #(.RAM_BYTES(RAM_BYTES)) u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .stk(stk)
    );

    // --------
    // programming value for the latched target
    // --------
    // any erase size selection turns the pulse into an erase
    assign erase_sel = st_q.ctrl[mm_pkg::ERASE_HI_BIT]
                       | st_q.ctrl[mm_pkg::ERASE_LO_BIT];

    // programming only clears bits, erase returns to blank
    always_comb begin
        if (erase_sel) begin
            prog_val = mm_pkg::NV_BLANK;
        end else if (st_q.latch_idx == mm_pkg::IDX_DIVH_NV) begin
            prog_val = st_q.nv_divh & st_q.latch_data;
        end else if (st_q.latch_idx == mm_pkg::IDX_DIVL_NV) begin
            prog_val = st_q.nv_divl & st_q.latch_data;
        end else begin
            prog_val = st_q.nv_prot & st_q.latch_data;
        end
    end

    // --------
    // next state
    // --------
    always_comb begin
        st_d = st_q;
        st_d.wdog_clr = 1'b0;

        // retire answers taken by the master
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // capture write address and data in either order
        if (st_q.awready && s_axi_awvalid) begin
            st_d.aw_have = 1'b1;
            st_d.aw_idx = s_axi_awaddr[17:2];
        end
        if (st_q.wready && s_axi_wvalid) begin
            st_d.w_have = 1'b1;
            st_d.wbyte = s_axi_wdata[7:0];
            st_d.wlane0 = s_axi_wstrb[0];
        end

        // perform write once both halves are in
        if (st_d.aw_have && st_d.w_have && !st_d.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = mm_pkg::RESP_OKAY;
            if (wr_region == mm_pkg::RGN_NONE) begin
                st_d.bresp = mm_pkg::RESP_DECERR;
            end else if (!st_d.wlane0) begin
                // no byte enabled for the data lane: nothing stored
                st_d.bresp = mm_pkg::RESP_OKAY;
            end else if (wr_region == mm_pkg::RGN_RAM) begin
                st_d.ram[wr_ram_off] = st_d.wbyte;
            end else if (wr_region == mm_pkg::RGN_VEC) begin
                if (st_d.aw_idx == mm_pkg::IDX_WDOG) begin
                    st_d.wdog_clr = 1'b1;
                end else begin
                    st_d.bresp = mm_pkg::RESP_SLVERR;
                end
            end else if (wr_region != mm_pkg::RGN_REG) begin
                st_d.bresp = mm_pkg::RESP_SLVERR;
            end else if (st_d.aw_idx == mm_pkg::IDX_DIVH) begin
                // divider locked once its security bit reads zero
                if (st_q.divh[mm_pkg::DIV_SEC_BIT]) begin
                    st_d.divh = st_d.wbyte & mm_pkg::DIVH_MASK;
                end
            end else if (st_d.aw_idx == mm_pkg::IDX_DIVL) begin
                if (st_q.divh[mm_pkg::DIV_SEC_BIT]) begin
                    st_d.divl = st_d.wbyte;
                end
            end else if (st_d.aw_idx == mm_pkg::IDX_CTRL) begin
                st_d.ctrl = st_d.wbyte & mm_pkg::CTRL_MASK;
                if (!st_d.wbyte[mm_pkg::LATCH_BIT]) begin
                    st_d.latched = 1'b0;
                end
                // pulse with latch set commits the latched byte
                if (st_d.wbyte[mm_pkg::PULSE_BIT]
                    && st_d.wbyte[mm_pkg::LATCH_BIT]
                    && st_q.latched) begin
                    st_d.latched = 1'b0;
                    if (st_q.latch_idx == mm_pkg::IDX_NVPROT) begin
                        if (st_q.nv_prot[mm_pkg::PROG_PROT_BIT]) begin
                            st_d.nv_prot = prog_val;
                        end
                    end else if (st_q.divh[mm_pkg::DIV_SEC_BIT]) begin
                        if (st_q.latch_idx == mm_pkg::IDX_DIVH_NV) begin
                            st_d.nv_divh = prog_val;
                        end else begin
                            st_d.nv_divl = prog_val;
                        end
                    end
                end
            end else if (st_d.aw_idx == mm_pkg::IDX_NVPROT
                         || st_d.aw_idx == mm_pkg::IDX_DIVH_NV
                         || st_d.aw_idx == mm_pkg::IDX_DIVL_NV) begin
                // plain writes ignored; with latch set they arm a cycle
                if (st_q.ctrl[mm_pkg::LATCH_BIT]) begin
                    st_d.latched = 1'b1;
                    st_d.latch_idx = st_d.aw_idx;
                    st_d.latch_data = st_d.wbyte;
                end
            end
            // the active protect copy is read only
        end

        // perform read on acceptance
        if (st_q.arready && s_axi_arvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = mm_pkg::RESP_OKAY;
            st_d.rbyte = 8'h00;
            if (rd_region == mm_pkg::RGN_RAM) begin
                st_d.rbyte = st_q.ram[rd_ram_off];
            end else if (rd_region == mm_pkg::RGN_UROM
                         || rd_region == mm_pkg::RGN_MROM) begin
                // rom contents live outside; blocked while secured
                if (rom_secure) begin
                    st_d.rresp = mm_pkg::RESP_SLVERR;
                end
            end else if (rd_region == mm_pkg::RGN_VEC) begin
                if (rd_vec_off == mm_pkg::VEC_RESET_HI) begin
                    st_d.rbyte = RESET_VECTOR[15:8];
                end else if (rd_vec_off == mm_pkg::VEC_RESET_LO) begin
                    st_d.rbyte = RESET_VECTOR[7:0];
                end else begin
                    st_d.rbyte = VECTORS[rd_vec_off];
                end
            end else if (rd_region == mm_pkg::RGN_NONE) begin
                st_d.rresp = mm_pkg::RESP_DECERR;
            end else if (rd_idx == mm_pkg::IDX_DIVH) begin
                st_d.rbyte = st_q.divh;
            end else if (rd_idx == mm_pkg::IDX_DIVL) begin
                st_d.rbyte = st_q.divl;
            end else if (rd_idx == mm_pkg::IDX_NVPROT) begin
                st_d.rbyte = st_q.nv_prot;
                // reading the nv copy refreshes the active protection
                st_d.prot_act = st_q.nv_prot;
            end else if (rd_idx == mm_pkg::IDX_CTRL) begin
                st_d.rbyte = st_q.ctrl;
            end else if (rd_idx == mm_pkg::IDX_PROT_ACT) begin
                st_d.rbyte = st_q.prot_act;
            end else if (rd_idx == mm_pkg::IDX_DIVH_NV) begin
                st_d.rbyte = st_q.nv_divh;
            end else begin
                st_d.rbyte = st_q.nv_divl;
            end
        end

        // power-on gives blank divider copies, factory protect value
        if (!por_n) begin
            st_d.nv_divh = mm_pkg::NV_BLANK;
            st_d.nv_divl = mm_pkg::NV_BLANK;
            st_d.nv_prot = mm_pkg::NVPROT_FACTORY;
        end

        // reset: ram and nv copies kept, volatile copies reloaded
        if (!aresetn) begin
            st_d.divh = st_d.nv_divh & mm_pkg::DIVH_MASK;
            st_d.divl = st_d.nv_divl;
            st_d.prot_act = st_d.nv_prot;
            st_d.ctrl = mm_pkg::CTRL_RST;
            st_d.latched = 1'b0;
            st_d.latch_idx = 16'h0000;
            st_d.latch_data = 8'h00;
            st_d.aw_have = 1'b0;
            st_d.aw_idx = 16'h0000;
            st_d.w_have = 1'b0;
            st_d.wbyte = 8'h00;
            st_d.wlane0 = 1'b0;
            st_d.bvalid = 1'b0;
            st_d.bresp = mm_pkg::RESP_OKAY;
            st_d.rvalid = 1'b0;
            st_d.rresp = mm_pkg::RESP_OKAY;
            st_d.rbyte = 8'h00;
            st_d.wdog_clr = 1'b0;
        end

        // one write and one read in flight at a time
        st_d.awready = aresetn && !st_d.aw_have && !st_d.bvalid;
        st_d.wready = aresetn && !st_d.w_have && !st_d.bvalid;
        st_d.arready = aresetn && !st_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    // --------
    // outputs, all from registers
    // --------
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = {24'h00_0000, st_q.rbyte};
    assign stack_ptr = stk.sp;
    assign stack_in_ram = stk.in_ram;
    assign timebase_divider = {st_q.divh[2:0], st_q.divl};
    assign divider_security_bit = st_q.divh[mm_pkg::DIV_SEC_BIT];
    assign array_protect_active = st_q.prot_act;
    assign array_program_control = st_q.ctrl;
    assign watchdog_clear = st_q.wdog_clr;
endmodule : mm_map_top
`default_nettype wire

// ===== design/mm_pkg.sv
`default_nettype none
package mm_pkg;
    // --------
    // address map
    // --------
    localparam logic [15:0] RAM_FIRST = 16'h0050;
    localparam logic [15:0] RAM_LAST = 16'h044F;
    localparam logic [15:0] PAGE0_LAST = 16'h00FF;
    localparam logic [15:0] UROM_FIRST = 16'h8000;
    localparam logic [15:0] UROM_LAST = 16'hFDFF;
    localparam logic [15:0] MROM_FIRST = 16'hFE20;
    localparam logic [15:0] MROM_LAST = 16'hFEFF;
    localparam logic [15:0] VEC_FIRST = 16'hFFDA;
    localparam logic [15:0] VEC_LAST = 16'hFFFF;
    localparam logic [5:0] VEC_RESET_HI = 6'h24;
    localparam logic [5:0] VEC_RESET_LO = 6'h25;
    // --------
    // register indices (byte address is four times these)
    // --------
    localparam logic [15:0] IDX_DIVH_NV = 16'hFE10;
    localparam logic [15:0] IDX_DIVL_NV = 16'hFE11;
    localparam logic [15:0] IDX_DIVH = 16'hFE1A;
    localparam logic [15:0] IDX_DIVL = 16'hFE1B;
    localparam logic [15:0] IDX_NVPROT = 16'hFE1C;
    localparam logic [15:0] IDX_CTRL = 16'hFE1D;
    localparam logic [15:0] IDX_PROT_ACT = 16'hFE1F;
    localparam logic [15:0] IDX_WDOG = 16'hFFFF;
    // --------
    // fields and reset values
    // --------
    localparam int DIV_SEC_BIT = 7;
    localparam logic [7:0] DIVH_MASK = 8'h87;
    localparam int PROG_PROT_BIT = 4;
    localparam int ARRAY_OFF_BIT = 5;
    localparam int ERASE_HI_BIT = 4;
    localparam int ERASE_LO_BIT = 3;
    localparam int LATCH_BIT = 2;
    localparam int AUTO_BIT = 1;
    localparam int PULSE_BIT = 0;
    localparam logic [7:0] CTRL_MASK = 8'h3F;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] NV_BLANK = 8'hFF;
    localparam logic [7:0] NVPROT_FACTORY = 8'hF0;
    localparam logic [15:0] SP_RST = 16'h00FF;
    localparam logic [15:0] IRQ_FRAME = 16'h0005;
    localparam logic [15:0] CALL_FRAME = 16'h0002;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // --------
    // enumerations
    // --------
    typedef enum logic [2:0] {
        RGN_NONE, RGN_RAM, RGN_UROM, RGN_MROM, RGN_VEC, RGN_REG
    } mm_region_t;
    typedef enum logic [2:0] {
        SOP_NONE, SOP_PUSH, SOP_PULL, SOP_IRQ, SOP_RTI, SOP_CALL,
        SOP_RET, SOP_LOAD
    } mm_sop_t;
endpackage : mm_pkg
`default_nettype wire

// ===== design/mm_stack_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mm_stack_if;
    mm_pkg::mm_sop_t op;
    logic [15:0] load_val;
    logic [15:0] sp;
    logic in_ram;
    modport unit (input op, input load_val, output sp, output in_ram);
    modport user (output op, output load_val, input sp, input in_ram);
endinterface : mm_stack_if
`default_nettype wire

// ===== design/mm_stack_ptr.sv
`timescale 1ns/1ns
`default_nettype none
module mm_stack_ptr #(
    parameter int unsigned RAM_BYTES = 1024
) (
    input wire logic aclk,
    input wire logic aresetn,
    mm_stack_if.unit stk
);
    localparam logic [15:0] RAM_END = 16'(mm_pkg::RAM_FIRST + RAM_BYTES - 1);
    typedef struct packed {
        logic [15:0] sp;
        logic in_ram;
    } mm_stk_st_t;
    mm_stk_st_t st_q;
    mm_stk_st_t st_d;

    // pointer arithmetic per stack operation
    always_comb begin
        st_d = st_q;
        case (stk.op)
            mm_pkg::SOP_PUSH: st_d.sp = st_q.sp - 16'h0001;
            mm_pkg::SOP_PULL: st_d.sp = st_q.sp + 16'h0001;
            // pc, x, a, ccr only; index high not saved
            mm_pkg::SOP_IRQ: st_d.sp = st_q.sp - mm_pkg::IRQ_FRAME;
            mm_pkg::SOP_RTI: st_d.sp = st_q.sp + mm_pkg::IRQ_FRAME;
            mm_pkg::SOP_CALL: st_d.sp = st_q.sp - mm_pkg::CALL_FRAME;
            mm_pkg::SOP_RET: st_d.sp = st_q.sp + mm_pkg::CALL_FRAME;
            mm_pkg::SOP_LOAD: st_d.sp = stk.load_val;
            default: st_d.sp = st_q.sp;
        endcase
        if (!aresetn) begin
            st_d.sp = mm_pkg::SP_RST;
        end
        // flag a pointer inside ram
        st_d.in_ram = st_d.sp >= mm_pkg::RAM_FIRST && st_d.sp <= RAM_END;
    end

    always_ff @(posedge aclk) begin
        st_q <= st_d;
    end

    assign stk.sp = st_q.sp;
    assign stk.in_ram = st_q.in_ram;
endmodule : mm_stack_ptr
`default_nettype wire

// ===== verif/mm_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mm_cpu_model (
    input wire logic aclk,
    output var mm_pkg::mm_sop_t cpu_stack_op,
    output var logic [15:0] cpu_sp_load_val
);
    // --------
    // core side of the stack port
    // --------
    initial begin
        cpu_stack_op = mm_pkg::SOP_NONE;
        cpu_sp_load_val = 16'h0000;
    end
    // one op for one edge, then idle with a changed value
    task automatic step(input mm_pkg::mm_sop_t op, input logic [15:0] v);
        cpu_stack_op <= op;
        cpu_sp_load_val <= v;
        @(posedge aclk);
        cpu_stack_op <= mm_pkg::SOP_NONE;
        cpu_sp_load_val <= ~v;
    endtask : step
endmodule : mm_cpu_model
`default_nettype wire

// ===== verif/mm_map_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mm_map_props #(
    parameter int unsigned RAM_BYTES = 1024
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mm_pkg::mm_sop_t cpu_stack_op,
    input wire logic [15:0] cpu_sp_load_val,
    input wire logic [15:0] stack_ptr,
    input wire logic stack_in_ram,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] array_program_control,
    input wire logic watchdog_clear
);
    // --------
    // stack, control, watchdog and read data checks
    // --------
    localparam logic [15:0] RAM_TOP = 16'(16'h004f + RAM_BYTES);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_SP_RST: assert property (disable iff (1'h0)
        !aresetn |=> stack_ptr == 16'h00ff) else $error("sp reset");
    AST_SP_PUSH: assert property (cpu_stack_op == mm_pkg::SOP_PUSH
        |=> stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push");
    AST_SP_PULL: assert property (cpu_stack_op == mm_pkg::SOP_PULL
        |=> stack_ptr == $past(stack_ptr) + 16'h0001) else $error("pull");
    AST_SP_IRQ: assert property (cpu_stack_op == mm_pkg::SOP_IRQ
        |=> stack_ptr == $past(stack_ptr) - 16'h0005) else $error("irq");
    AST_SP_CALL: assert property (cpu_stack_op == mm_pkg::SOP_CALL
        |=> stack_ptr == $past(stack_ptr) - 16'h0002) else $error("call");
    AST_SP_LOAD: assert property (cpu_stack_op == mm_pkg::SOP_LOAD
        |=> stack_ptr == $past(cpu_sp_load_val)) else $error("load");
    AST_IN_RAM: assert property (stack_in_ram ==
        (stack_ptr >= 16'h0050 && stack_ptr <= RAM_TOP)) else $error("ram");
    AST_CTRL_RST: assert property (disable iff (1'h0)
        !aresetn |=> array_program_control == 8'h00) else $error("ctrl");
    AST_CTRL_RSVD: assert property (array_program_control[7:6] == 2'h0)
        else $error("ctrl reserved");
    AST_WDOG_PULSE: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("watchdog pulse");
    AST_RDATA_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
        else $error("rdata upper");
    // main scenarios reached
    cover property (cpu_stack_op == mm_pkg::SOP_IRQ);
    cover property (watchdog_clear);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : mm_map_props
bind mm_map_top mm_map_props #(.RAM_BYTES(RAM_BYTES)) u_props (
    .aclk(aclk), .aresetn(aresetn), .cpu_stack_op(cpu_stack_op),
    .cpu_sp_load_val(cpu_sp_load_val), .stack_ptr(stack_ptr),
    .stack_in_ram(stack_in_ram), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .array_program_control(array_program_control),
    .watchdog_clear(watchdog_clear));
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    // --------
    // stimulus, tables and checks
    // --------
    logic aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0, rom_sec = 1'h0;
    logic [17:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic awr, wrdy, bv, arr, rv, inram, secb, wdc;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] apc, apa;
    logic [15:0] sp, ld;
    logic [10:0] tdiv;
    mm_pkg::mm_sop_t op;
    int bad_count = 0, samples_checked = 0, wd_n = 0;
    localparam logic [15:0] RA [9] = '{16'hfe1a, 16'hfe1b, 16'hfe1c,
        16'hfe1d, 16'hfe1f, 16'hfe1e, 16'hffff, 16'hffda, 16'hfffd};
    localparam logic [7:0] RX [9] = '{8'h87, 8'hff, 8'hf0, 8'h00, 8'hf0,
        8'h00, 8'ha5, 8'h3c, 8'h5a};
    localparam mm_pkg::mm_sop_t OPS [8] = '{mm_pkg::SOP_PUSH,
        mm_pkg::SOP_IRQ, mm_pkg::SOP_RTI, mm_pkg::SOP_CALL, mm_pkg::SOP_RET,
        mm_pkg::SOP_PULL, mm_pkg::SOP_LOAD, mm_pkg::SOP_LOAD};
    localparam logic [15:0] SPX [8] = '{16'h00fe, 16'h00f9, 16'h00fe,
        16'h00fc, 16'h00fe, 16'h00ff, 16'h044f, 16'h0450};
    always #50 aclk = ~aclk;
    // counts watchdog clear pulses
    always @(posedge aclk) if (wdc) wd_n <= wd_n + 1;
    mm_map_top #(.RESET_VECTOR(16'h80a5),
        .VECTORS({8'h5a, 272'h0, 8'h3c})) uut (
        .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .rom_secure(rom_sec),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .cpu_stack_op(op),
        .cpu_sp_load_val(ld), .stack_ptr(sp), .stack_in_ram(inram),
        .timebase_divider(tdiv), .divider_security_bit(secb),
        .array_protect_active(apa), .array_program_control(apc),
        .watchdog_clear(wdc));
    mm_cpu_model cpu (.aclk(aclk), .cpu_stack_op(op), .cpu_sp_load_val(ld));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        awa <= {a, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
            if (bv) begin
                resp = bresp;
                break;
            end
        end
    endtask : wr
    task automatic rchk(input logic [15:0] a, input logic [7:0] x,
        input logic [1:0] xr);
        ara <= {a, 2'h0};
        arv <= 1'h1;
        rr <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
            if (rv) begin
                chk(rd, {24'h0, x});
                chk(rresp, xr);
                break;
            end
        end
    endtask : rchk
    task automatic prog(input logic [15:0] a, input logic [7:0] m, d);
        wr(16'hfe1d, m | 8'h04);
        wr(a, d);
        wr(16'hfe1d, m | 8'h05);
        wr(16'hfe1d, 8'h00);
    endtask : prog
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // hang guard
    initial begin
        repeat (3000) @(posedge aclk);
        bad_count++;
        $display("BAD %0t timeout", $time);
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        por_n <= 1'h1;
        @(posedge aclk);
        chk(tdiv, 11'h7ff);
        for (int i = 0; i < 9; i++) begin
            rchk(RA[i], RX[i], (i == 5) ? 2'h3 : 2'h0);
        end
        $display("reset values done");
        wr(16'hfe1d, 8'he4);
        rchk(16'hfe1d, 8'h24, 2'h0);
        chk(apc, 8'h24);
        wr(16'hfe1d, 8'h00);
        wr(16'hfe1c, 8'h00);
        wr(16'hfe1f, 8'h00);
        rchk(16'hfe1c, 8'hf0, 2'h0);
        rchk(16'hfe1f, 8'hf0, 2'h0);
        wr(16'h8000, 8'h11);
        chk(resp, 2'h2);
        wr(16'hffff, 8'h00);
        repeat (3) @(posedge aclk);
        chk(wd_n, 1);
        rom_sec <= 1'h1;
        rchk(16'h8000, 8'h00, 2'h2);
        rom_sec <= 1'h0;
        rchk(16'hfdff, 8'h00, 2'h0);
        rchk(16'hfe20, 8'h00, 2'h0);
        wr(16'h0050, 8'ha5);
        wr(16'h00ff, 8'hc3);
        wr(16'h044f, 8'h5a);
        rchk(16'h0050, 8'ha5, 2'h0);
        rchk(16'h00ff, 8'hc3, 2'h0);
        rchk(16'h044f, 8'h5a, 2'h0);
        rchk(16'h0450, 8'h00, 2'h3);
        $display("map done");
        for (int i = 0; i < 8; i++) begin
            cpu.step(OPS[i], SPX[i]);
            @(posedge aclk);
            chk(sp, SPX[i]);
            chk(inram, i != 7);
        end
        $display("stack done");
        prog(16'hfe1c, 8'h08, 8'h00);
        rchk(16'hfe1c, 8'hff, 2'h0);
        @(posedge aclk);
        chk(apa, 8'hff);
        prog(16'hfe1c, 8'h00, 8'hf7);
        prog(16'hfe10, 8'h00, 8'hc2);
        prog(16'hfe11, 8'h00, 8'h5a);
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk(sp, 16'h00ff);
        chk(tdiv, 11'h25a);
        chk(secb, 1'h1);
        rchk(16'hfe1c, 8'hf7, 2'h0);
        rchk(16'hfe1f, 8'hf7, 2'h0);
        rchk(16'hfe1a, 8'h82, 2'h0);
        rchk(16'hfe1b, 8'h5a, 2'h0);
        $display("nonvolatile done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
